// ==== pkg/isr_regs.svh ====
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH
// Function
// RULE1 - Keep 8-bit status byte, read by query or poll
// RULE2 - Service enable mask gates service request
// RULE3 - Query bit 6 returns master summary status
// RULE4 - 8-bit standard event register with enable mask
// RULE5 - Standard event summary sits in bit 5
// RULE6 - 16-bit operation set summarises into bit 7
// RULE7 - 16-bit questionable set summarises into bit 3
// RULE8 - Power set summarises into questionable bit 3
// RULE9 - Frequency set summarises into questionable bit 5
// RULE10 - Calibration condition summarises into questionable bit 8
// RULE11 - A one in any status bit means set
// RULE12 - Output queue holds responses until read
// RULE13 - Error queue holds twenty number and text entries
// RULE14 - Each detected error appends an entry
// RULE15 - Error query moves oldest entry to output queue
// RULE16 - Event AND enable bits OR into summary
// RULE17 - Events stick until event read or clear
// RULE18 - Serial poll clears request bit, others untouched
// RULE19 - Full error queue drops new errors

// ****************************************************************
// Status byte bit positions
// ****************************************************************
`define ISR_STB_ERB 2
`define ISR_STB_QUES 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OPER 7

// ****************************************************************
// Questionable bits fed by lower register sets
// ****************************************************************
`define ISR_QUES_POWER 3
`define ISR_QUES_FREQ 5
`define ISR_QUES_CAL 8

// ****************************************************************
// Widths, depths and reset values
// ****************************************************************
`define ISR_STD_W 8
`define ISR_REG_W 16
`define ISR_ERR_CODE_W 16
`define ISR_ERR_TEXT_W 8
`define ISR_ERRQ_DEPTH 20
`define ISR_OUTQ_DEPTH 8
`define ISR_RESP_W 24
`define ISR_ENABLE_RESET 16'h0000

// ****************************************************************
// Fixed transition filters
// ****************************************************************
`define ISR_OPER_POS 16'hFFFF
`define ISR_OPER_NEG 16'h0000
`define ISR_QUES_POS 16'hFFFF
`define ISR_QUES_NEG 16'h0000
`define ISR_PWR_POS 16'hFFFF
`define ISR_PWR_NEG 16'h0000
`define ISR_FREQ_POS 16'hFFFF
`define ISR_FREQ_NEG 16'h0000

`endif

// ==== pkg/isr_pkg.sv ====
package isr_pkg;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    typedef enum logic [4:0] {
        ISR_CMD_STB_Q = 5'h00,
        ISR_CMD_ESR_Q = 5'h01,
        ISR_CMD_OPER_COND_Q = 5'h02,
        ISR_CMD_OPER_EVT_Q = 5'h03,
        ISR_CMD_QUES_COND_Q = 5'h04,
        ISR_CMD_QUES_EVT_Q = 5'h05,
        ISR_CMD_PWR_COND_Q = 5'h06,
        ISR_CMD_PWR_EVT_Q = 5'h07,
        ISR_CMD_FREQ_COND_Q = 5'h08,
        ISR_CMD_FREQ_EVT_Q = 5'h09,
        ISR_CMD_CAL_COND_Q = 5'h0A,
        ISR_CMD_ERR_Q = 5'h0B,
        ISR_CMD_CLS = 5'h0C,
        ISR_CMD_SRE_W = 5'h0D,
        ISR_CMD_ESE_W = 5'h0E,
        ISR_CMD_OPER_EN_W = 5'h0F,
        ISR_CMD_QUES_EN_W = 5'h10,
        ISR_CMD_PWR_EN_W = 5'h11,
        ISR_CMD_FREQ_EN_W = 5'h12,
        ISR_CMD_SRE_Q = 5'h13,
        ISR_CMD_ESE_Q = 5'h14,
        ISR_CMD_OPER_EN_Q = 5'h15,
        ISR_CMD_QUES_EN_Q = 5'h16,
        ISR_CMD_PWR_EN_Q = 5'h17,
        ISR_CMD_FREQ_EN_Q = 5'h18
    } isr_cmd_type;

    // ****************************************************************
    // Command sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ISR_ST_IDLE = 2'h1,
        ISR_ST_ERR = 2'h2
    } isr_state_type;

endpackage : isr_pkg

// ==== core/isr_event_set.sv ====
`timescale 1ns/1ps
module isr_event_set #(
    parameter int W = 16,
    parameter logic [W-1:0] POS = '1,
    parameter logic [W-1:0] NEG = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] cond,
    input wire logic en_we,
    input wire logic [W-1:0] en_wdata,
    input wire logic evt_rd,
    input wire logic cls,
    output logic [W-1:0] evt,
    output logic [W-1:0] enable,
    output logic summary
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] evt;
        logic [W-1:0] en;
    } isr_es_state_type;

    isr_es_state_type cur;
    isr_es_state_type next_cur;

    // ****************************************************************
    // Transition filter, sticky events, enable mask
    // ****************************************************************
    always_comb begin
        logic [W-1:0] trans;
        trans = '0;
        next_cur = cur;
        if (ce) begin
            trans = (~cur.prev & cond & POS) | (cur.prev & ~cond & NEG);
            // New transition wins over a clear in the same cycle
            next_cur.evt = ((evt_rd || cls) ? '0 : cur.evt) | trans; // see RULE17
            next_cur.prev = cond;
            if (cls) begin
                next_cur.en = '0;
            end else if (en_we) begin
                next_cur.en = en_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign evt = cur.evt;
    assign enable = cur.en;
    assign summary = |(cur.evt & cur.en); // see RULE16

endmodule : isr_event_set

// ==== core/isr_queue.sv ====
`timescale 1ns/1ps
module isr_queue #(
    parameter int W = 24,
    parameter int DEPTH = 20,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic full,
    output logic empty,
    output logic [W-1:0] rd_data,
    output logic rd_valid
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [W-1:0] rd_data;
        logic rd_valid;
    } isr_q_state_type;

    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    isr_q_state_type cur;
    isr_q_state_type next_cur;

    // ****************************************************************
    // Circular store with registered read port
    // ****************************************************************
    always_comb begin
        logic do_push;
        logic do_pop;
        do_push = 1'b0;
        do_pop = 1'b0;
        next_cur = cur;
        if (ce) begin
            do_push = push && (cur.cnt != FULL_CNT); // see RULE19
            do_pop = pop && (cur.cnt != '0);
            next_cur.rd_valid = do_pop;
            if (do_push) begin
                next_cur.mem[cur.wp] = push_data;
                next_cur.wp = (cur.wp == LAST) ? '0 : cur.wp + 1'b1;
            end
            if (do_pop) begin
                next_cur.rd_data = cur.mem[cur.rp];
                next_cur.rp = (cur.rp == LAST) ? '0 : cur.rp + 1'b1;
            end
            if (do_push && !do_pop) begin
                next_cur.cnt = cur.cnt + 1'b1;
            end else if (do_pop && !do_push) begin
                next_cur.cnt = cur.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign full = (cur.cnt == FULL_CNT);
    assign empty = (cur.cnt == '0);
    assign rd_data = cur.rd_data;
    assign rd_valid = cur.rd_valid;

endmodule : isr_queue

// ==== core/isr_status_core.sv ====
`timescale 1ns/1ps
`include "isr_regs.svh"
module isr_status_core #(
    parameter int ERRQ_DEPTH = `ISR_ERRQ_DEPTH,
    parameter int OUTQ_DEPTH = `ISR_OUTQ_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire isr_pkg::isr_cmd_type cmd_op,
    input wire logic [`ISR_REG_W-1:0] cmd_wdata,
    output logic cmd_ready,
    input wire logic [`ISR_STD_W-1:0] std_evt_set,
    input wire logic [`ISR_REG_W-1:0] oper_cond,
    input wire logic [`ISR_REG_W-1:0] ques_cond,
    input wire logic [`ISR_REG_W-1:0] power_cond,
    input wire logic [`ISR_REG_W-1:0] freq_cond,
    input wire logic [`ISR_REG_W-1:0] cal_cond,
    input wire logic err_valid,
    input wire logic [`ISR_ERR_CODE_W-1:0] err_code,
    input wire logic [`ISR_ERR_TEXT_W-1:0] err_text,
    input wire logic resp_rd,
    output logic [`ISR_RESP_W-1:0] resp_data,
    output logic resp_valid,
    input wire logic poll_req,
    output logic [7:0] poll_data,
    output logic poll_valid,
    output logic srq,
    output logic [7:0] status_byte
);

    localparam int EW = `ISR_ERR_CODE_W + `ISR_ERR_TEXT_W;

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        isr_pkg::isr_state_type state;
        logic [7:0] sre;
        logic [`ISR_STD_W-1:0] ese;
        logic [`ISR_STD_W-1:0] std_evt;
        logic reason_q;
        logic rqs;
        logic [7:0] stb;
        logic [7:0] poll_data;
        logic poll_valid;
    } isr_core_state_type;

    isr_core_state_type cur;
    isr_core_state_type next_cur;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic isr_hit(
        input logic take,
        input isr_pkg::isr_cmd_type op,
        input isr_pkg::isr_cmd_type want
    );
        isr_hit = take && (op == want);
    endfunction : isr_hit

    function automatic logic [`ISR_RESP_W-1:0] isr_pad(
        input logic [`ISR_REG_W-1:0] v
    );
        isr_pad = {{(`ISR_RESP_W - `ISR_REG_W){1'b0}}, v};
    endfunction : isr_pad

    // ****************************************************************
    // Command acceptance
    // ****************************************************************
    logic take;
    logic cls;
    logic outq_full;
    logic outq_empty;
    logic errq_full;
    logic errq_empty;
    logic [EW-1:0] errq_rd_data;
    logic errq_rd_valid;
    logic errq_pop;
    logic outq_push;
    logic [`ISR_RESP_W-1:0] outq_push_data;

    assign cmd_ready = ce && (cur.state == isr_pkg::ISR_ST_IDLE) && !outq_full;
    assign take = cmd_valid && cmd_ready;
    assign cls = isr_hit(take, cmd_op, isr_pkg::ISR_CMD_CLS);

    // ****************************************************************
    // Register sets
    // ****************************************************************
    logic [`ISR_REG_W-1:0] oper_evt;
    logic [`ISR_REG_W-1:0] oper_en;
    logic oper_sum;
    logic [`ISR_REG_W-1:0] ques_full;
    logic [`ISR_REG_W-1:0] ques_evt;
    logic [`ISR_REG_W-1:0] ques_en;
    logic ques_sum;
    logic [`ISR_REG_W-1:0] pwr_evt;
    logic [`ISR_REG_W-1:0] pwr_en;
    logic pwr_sum;
    logic [`ISR_REG_W-1:0] freq_evt;
    logic [`ISR_REG_W-1:0] freq_en;
    logic freq_sum;
    logic cal_sum;

    isr_event_set #(
        .W(`ISR_REG_W),
        .POS(`ISR_OPER_POS),
        .NEG(`ISR_OPER_NEG)
    ) u_oper (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cond(oper_cond),
        .en_we(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_OPER_EN_W)),
        .en_wdata(cmd_wdata),
        .evt_rd(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_OPER_EVT_Q)),
        .cls(cls),
        .evt(oper_evt),
        .enable(oper_en),
        .summary(oper_sum)
    ); // see RULE6

    isr_event_set #(
        .W(`ISR_REG_W),
        .POS(`ISR_PWR_POS),
        .NEG(`ISR_PWR_NEG)
    ) u_pwr (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cond(power_cond),
        .en_we(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_PWR_EN_W)),
        .en_wdata(cmd_wdata),
        .evt_rd(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_PWR_EVT_Q)),
        .cls(cls),
        .evt(pwr_evt),
        .enable(pwr_en),
        .summary(pwr_sum)
    ); // see RULE8

    isr_event_set #(
        .W(`ISR_REG_W),
        .POS(`ISR_FREQ_POS),
        .NEG(`ISR_FREQ_NEG)
    ) u_freq (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cond(freq_cond),
        .en_we(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_FREQ_EN_W)),
        .en_wdata(cmd_wdata),
        .evt_rd(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_FREQ_EVT_Q)),
        .cls(cls),
        .evt(freq_evt),
        .enable(freq_en),
        .summary(freq_sum)
    ); // see RULE9

    // Calibration has only a condition view
    assign cal_sum = |cal_cond; // see RULE10

    // Lower set summaries overwrite their questionable bits
    always_comb begin
        ques_full = ques_cond;
        ques_full[`ISR_QUES_POWER] = pwr_sum; // see RULE8
        ques_full[`ISR_QUES_FREQ] = freq_sum; // see RULE9
        ques_full[`ISR_QUES_CAL] = cal_sum; // see RULE10
    end

    isr_event_set #(
        .W(`ISR_REG_W),
        .POS(`ISR_QUES_POS),
        .NEG(`ISR_QUES_NEG)
    ) u_ques (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .cond(ques_full),
        .en_we(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_QUES_EN_W)),
        .en_wdata(cmd_wdata),
        .evt_rd(isr_hit(take, cmd_op, isr_pkg::ISR_CMD_QUES_EVT_Q)),
        .cls(cls),
        .evt(ques_evt),
        .enable(ques_en),
        .summary(ques_sum)
    ); // see RULE7

    // ****************************************************************
    // Queues
    // ****************************************************************
    isr_queue #(
        .W(EW),
        .DEPTH(ERRQ_DEPTH)
    ) u_errq (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .push(err_valid), // see RULE14
        .push_data({err_code, err_text}), // see RULE13
        .pop(errq_pop),
        .full(errq_full),
        .empty(errq_empty),
        .rd_data(errq_rd_data),
        .rd_valid(errq_rd_valid)
    );

    isr_queue #(
        .W(`ISR_RESP_W),
        .DEPTH(OUTQ_DEPTH)
    ) u_outq (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .push(outq_push),
        .push_data(outq_push_data),
        .pop(resp_rd),
        .full(outq_full),
        .empty(outq_empty),
        .rd_data(resp_data),
        .rd_valid(resp_valid)
    ); // see RULE12

    // ****************************************************************
    // Status byte composition
    // ****************************************************************
    logic esb;
    logic [7:0] stb_raw;
    logic mss;
    logic reason;

    assign esb = |(cur.std_evt & cur.ese); // see RULE16
    always_comb begin
        stb_raw = 8'h00;
        stb_raw[`ISR_STB_OPER] = oper_sum; // see RULE6
        stb_raw[`ISR_STB_ESB] = esb; // see RULE5
        stb_raw[`ISR_STB_MAV] = !outq_empty;
        stb_raw[`ISR_STB_QUES] = ques_sum; // see RULE7
        stb_raw[`ISR_STB_ERB] = !errq_empty;
    end
    assign mss = |stb_raw; // see RULE3
    assign reason = |(stb_raw & cur.sre); // see RULE2

    // ****************************************************************
    // Response selection
    // ****************************************************************
    always_comb begin
        logic [7:0] q_stb;
        q_stb = stb_raw;
        q_stb[`ISR_STB_RQS] = mss; // see RULE3
        outq_push = 1'b0;
        outq_push_data = '0;
        errq_pop = 1'b0;
        if (cur.state == isr_pkg::ISR_ST_ERR) begin
            outq_push = errq_rd_valid; // see RULE15
            outq_push_data = isr_pad(16'h0000) | errq_rd_data;
        end else if (take) begin
            outq_push = 1'b1;
            unique case (cmd_op)
                isr_pkg::ISR_CMD_STB_Q: outq_push_data = isr_pad({8'h00, q_stb});
                isr_pkg::ISR_CMD_ESR_Q: begin
                    outq_push_data = isr_pad({8'h00, cur.std_evt}); // see RULE4
                end
                isr_pkg::ISR_CMD_OPER_COND_Q: outq_push_data = isr_pad(oper_cond);
                isr_pkg::ISR_CMD_OPER_EVT_Q: outq_push_data = isr_pad(oper_evt);
                isr_pkg::ISR_CMD_QUES_COND_Q: outq_push_data = isr_pad(ques_full);
                isr_pkg::ISR_CMD_QUES_EVT_Q: outq_push_data = isr_pad(ques_evt);
                isr_pkg::ISR_CMD_PWR_COND_Q: outq_push_data = isr_pad(power_cond);
                isr_pkg::ISR_CMD_PWR_EVT_Q: outq_push_data = isr_pad(pwr_evt);
                isr_pkg::ISR_CMD_FREQ_COND_Q: outq_push_data = isr_pad(freq_cond);
                isr_pkg::ISR_CMD_FREQ_EVT_Q: outq_push_data = isr_pad(freq_evt);
                isr_pkg::ISR_CMD_CAL_COND_Q: outq_push_data = isr_pad(cal_cond);
                isr_pkg::ISR_CMD_ERR_Q: begin
                    // Empty queue answers zero at once
                    outq_push = errq_empty;
                    errq_pop = !errq_empty; // see RULE15
                end
                isr_pkg::ISR_CMD_SRE_Q: outq_push_data = isr_pad({8'h00, cur.sre});
                isr_pkg::ISR_CMD_ESE_Q: outq_push_data = isr_pad({8'h00, cur.ese});
                isr_pkg::ISR_CMD_OPER_EN_Q: outq_push_data = isr_pad(oper_en);
                isr_pkg::ISR_CMD_QUES_EN_Q: outq_push_data = isr_pad(ques_en);
                isr_pkg::ISR_CMD_PWR_EN_Q: outq_push_data = isr_pad(pwr_en);
                isr_pkg::ISR_CMD_FREQ_EN_Q: outq_push_data = isr_pad(freq_en);
                default: outq_push = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Sequencer, masks, request bit, poll
    // ****************************************************************
    always_comb begin
        logic [7:0] p_stb;
        p_stb = stb_raw;
        p_stb[`ISR_STB_RQS] = cur.rqs;
        next_cur = cur;
        if (ce) begin
            next_cur.poll_valid = 1'b0;
            unique case (cur.state)
                isr_pkg::ISR_ST_IDLE: begin
                    if (errq_pop) begin
                        next_cur.state = isr_pkg::ISR_ST_ERR;
                    end
                end
                isr_pkg::ISR_ST_ERR: begin
                    if (errq_rd_valid) begin
                        next_cur.state = isr_pkg::ISR_ST_IDLE;
                    end
                end
                default: next_cur.state = isr_pkg::ISR_ST_IDLE;
            endcase
            if (isr_hit(take, cmd_op, isr_pkg::ISR_CMD_SRE_W)) begin
                // Request bit position is never enabled
                next_cur.sre = cmd_wdata[7:0] & 8'hBF; // see RULE2
            end
            if (cls) begin
                next_cur.ese = 8'h00;
            end else if (isr_hit(take, cmd_op, isr_pkg::ISR_CMD_ESE_W)) begin
                next_cur.ese = cmd_wdata[7:0]; // see RULE4
            end
            // New events win over read or clear
            next_cur.std_evt = ((isr_hit(take, cmd_op, isr_pkg::ISR_CMD_ESR_Q)
                || cls) ? 8'h00 : cur.std_evt) | std_evt_set; // see RULE17
            next_cur.reason_q = reason;
            if (reason && !cur.reason_q) begin
                next_cur.rqs = 1'b1;
            end else if (!reason || poll_req) begin
                next_cur.rqs = 1'b0; // see RULE18
            end
            if (poll_req) begin
                next_cur.poll_data = p_stb; // see RULE1
                next_cur.poll_valid = 1'b1;
            end
            next_cur.stb = stb_raw;
            next_cur.stb[`ISR_STB_RQS] = mss; // see RULE11
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
            cur.state <= isr_pkg::ISR_ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign srq = cur.rqs;
    assign status_byte = cur.stb;
    assign poll_data = cur.poll_data;
    assign poll_valid = cur.poll_valid;

endmodule : isr_status_core

// ==== test/isr_core_asserts.sv ====
`timescale 1ns/1ps
module isr_core_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire isr_pkg::isr_cmd_type cmd_op,
    input wire logic cmd_ready,
    input wire logic err_valid,
    input wire logic resp_rd,
    input wire logic resp_valid,
    input wire logic poll_req,
    input wire logic [7:0] poll_data,
    input wire logic poll_valid,
    input wire logic srq,
    input wire logic [7:0] status_byte
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_mss_or: assert property (
        status_byte[6] == |{status_byte[7], status_byte[5:0]})
        else $error("summary bit wrong");
    chk_low_bits: assert property (
        status_byte[1:0] == 2'h0) else $error("low bits set");
    chk_resp_cause: assert property (
        resp_valid |-> $past(resp_rd)) else $error("stray response");
    chk_poll_answer: assert property (
        poll_req |=> poll_valid) else $error("poll not answered");
    chk_poll_cause: assert property (
        poll_valid |-> $past(poll_req)) else $error("stray poll");
    chk_poll_rqs: assert property (
        poll_req |=> poll_data[6] == $past(srq)) else $error("poll rqs");
    chk_erb_set: assert property (
        err_valid |-> ##[1:3] status_byte[2]) else $error("no erb");
    chk_mav_set: assert property (
        cmd_valid && cmd_ready && cmd_op == isr_pkg::ISR_CMD_ESR_Q
        |-> ##[1:3] status_byte[4]) else $error("no mav");
endmodule : isr_core_asserts

// ==== test/isr_host_model.sv ====
`timescale 1ns/1ps
module isr_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output isr_pkg::isr_cmd_type cmd_op,
    output logic [15:0] cmd_wdata,
    input wire logic cmd_ready,
    output logic resp_rd,
    input wire logic [23:0] resp_data,
    input wire logic resp_valid,
    output logic poll_req,
    input wire logic [7:0] poll_data,
    input wire logic poll_valid
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = isr_pkg::ISR_CMD_STB_Q;
        cmd_wdata = 16'h0000;
        resp_rd = 1'b0;
        poll_req = 1'b0;
    end
    task automatic send(input isr_pkg::isr_cmd_type op,
                        input logic [15:0] wd);
        int n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_wdata <= wd;
        @(negedge clk);
        while (!cmd_ready && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~wd;  // Released data no longer valid
    endtask : send
    task automatic query(input isr_pkg::isr_cmd_type op,
                         output logic [23:0] d);
        send(op, 16'h0000);
        repeat (4) @(posedge clk);
        resp_rd <= 1'b1;
        @(posedge clk);
        resp_rd <= 1'b0;
        @(negedge clk);
        d = resp_valid ? resp_data : 24'hXXXXXX;
    endtask : query
    task automatic poll(output logic [7:0] d);
        @(posedge clk);
        poll_req <= 1'b1;
        @(posedge clk);
        poll_req <= 1'b0;
        @(negedge clk);
        d = poll_valid ? poll_data : 8'hXX;
    endtask : poll
endmodule : isr_host_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] std_evt_set = 8'h00;
    logic [15:0] oper_cond = 16'h0000;
    logic [15:0] ques_cond = 16'h0000;
    logic [15:0] power_cond = 16'h0000;
    logic [15:0] freq_cond = 16'h0000;
    logic [15:0] cal_cond = 16'h0000;
    logic ce = 1'b1;
    logic err_valid = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic [7:0] err_text = 8'h00;
    logic cmd_valid, cmd_ready, resp_rd, resp_valid, poll_req;
    logic poll_valid, srq;
    isr_pkg::isr_cmd_type cmd_op;
    logic [15:0] cmd_wdata;
    logic [23:0] resp_data;
    logic [7:0] poll_data, status_byte;
    int fails = 0;
    int comparisons = 0;
    isr_status_core isr_status_core_inst (.*);
    isr_host_model isr_host_model_inst (.*);
    always #20 clk = ~clk;
    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic q(input isr_pkg::isr_cmd_type op,
                     input logic [23:0] exp);
        logic [23:0] d;
        repeat (3) @(posedge clk);
        isr_host_model_inst.query(op, d);
        chk(op.name(), exp, d);
    endtask : q
    task automatic w(input isr_pkg::isr_cmd_type op,
                     input logic [15:0] v);
        isr_host_model_inst.send(op, v);
    endtask : w
    task automatic evt(input logic [7:0] v);
        @(posedge clk);
        std_evt_set <= v;
        @(posedge clk);
        std_evt_set <= 8'h00;
        repeat (3) @(posedge clk);
    endtask : evt
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        logic [7:0] pd;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        q(isr_pkg::ISR_CMD_STB_Q, 24'h000000);
        evt(8'h21);
        q(isr_pkg::ISR_CMD_ESR_Q, 24'h000021);
        q(isr_pkg::ISR_CMD_ESR_Q, 24'h000000);
        w(isr_pkg::ISR_CMD_ESE_W, 16'h0001);
        evt(8'h01);
        q(isr_pkg::ISR_CMD_STB_Q, 24'h000060);
        q(isr_pkg::ISR_CMD_ESR_Q, 24'h000001);
        w(isr_pkg::ISR_CMD_OPER_EN_W, 16'h0004);
        @(posedge clk);
        oper_cond <= 16'h0004;
        q(isr_pkg::ISR_CMD_STB_Q, 24'h0000C0);
        q(isr_pkg::ISR_CMD_OPER_EVT_Q, 24'h000004);
        q(isr_pkg::ISR_CMD_OPER_EVT_Q, 24'h000000);
        q(isr_pkg::ISR_CMD_OPER_COND_Q, 24'h000004);
        w(isr_pkg::ISR_CMD_PWR_EN_W, 16'h0001);
        w(isr_pkg::ISR_CMD_FREQ_EN_W, 16'h0001);
        w(isr_pkg::ISR_CMD_QUES_EN_W, 16'h0100);
        @(posedge clk);
        power_cond <= 16'h0001;
        freq_cond <= 16'h0001;
        cal_cond <= 16'h0010;
        ques_cond <= 16'h0009;
        q(isr_pkg::ISR_CMD_QUES_COND_Q, 24'h000129);
        q(isr_pkg::ISR_CMD_PWR_EVT_Q, 24'h000001);
        q(isr_pkg::ISR_CMD_FREQ_COND_Q, 24'h000001);
        q(isr_pkg::ISR_CMD_CAL_COND_Q, 24'h000010);
        q(isr_pkg::ISR_CMD_STB_Q, 24'h000048);
        q(isr_pkg::ISR_CMD_QUES_COND_Q, 24'h000121);
        q(isr_pkg::ISR_CMD_QUES_EVT_Q, 24'h000129);
        q(isr_pkg::ISR_CMD_FREQ_EVT_Q, 24'h000001);
        q(isr_pkg::ISR_CMD_PWR_COND_Q, 24'h000001);
        q(isr_pkg::ISR_CMD_QUES_EN_Q, 24'h000100);
        q(isr_pkg::ISR_CMD_PWR_EN_Q, 24'h000001);
        w(isr_pkg::ISR_CMD_CLS, 16'h0000);
        q(isr_pkg::ISR_CMD_STB_Q, 24'h000000);
        q(isr_pkg::ISR_CMD_OPER_EN_Q, 24'h000000);
        w(isr_pkg::ISR_CMD_ESE_W, 16'h0001);
        q(isr_pkg::ISR_CMD_ESE_Q, 24'h000001);
        evt(8'h01);
        @(negedge clk);
        chk("srq", 24'h000000, {23'h0, srq});
        w(isr_pkg::ISR_CMD_SRE_W, 16'h0060);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("srq", 24'h000001, {23'h0, srq});
        q(isr_pkg::ISR_CMD_SRE_Q, 24'h000020);
        isr_host_model_inst.poll(pd);
        chk("poll", 24'h000060, {16'h0, pd});
        chk("srq", 24'h000000, {23'h0, srq});
        q(isr_pkg::ISR_CMD_STB_Q, 24'h000060);
        for (int i = 1; i <= 21; i++) begin
            @(posedge clk);
            err_valid <= 1'b1;
            err_code <= 16'(i);
            err_text <= 8'(i + 8'h80);
        end
        @(posedge clk);
        err_valid <= 1'b0;
        for (int i = 1; i <= 20; i++) begin
            q(isr_pkg::ISR_CMD_ERR_Q, {16'(i), 8'(i + 8'h80)});
        end
        q(isr_pkg::ISR_CMD_ERR_Q, 24'h000000);
        @(posedge clk);
        ce <= 1'b0;
        std_evt_set <= 8'h04;
        @(posedge clk);
        ce <= 1'b1;
        std_evt_set <= 8'h00;
        q(isr_pkg::ISR_CMD_ESR_Q, 24'h000001);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule : testbench
bind isr_status_core isr_core_asserts isr_core_asserts_inst (.*);
